/* File: common/eiocp_pkg.sv */
package eiocp_pkg;
  localparam int EIOCP_LINES = 4;
  localparam int EIOCP_ADC_BITS = 12;
  localparam int EIOCP_CLK_MHZ = 250;
  localparam int EIOCP_STEP_US = 100;
  localparam int EIOCP_MAX_DELAY_MS = 25;
  localparam int EIOCP_STEP_CYCLES = EIOCP_STEP_US * EIOCP_CLK_MHZ;
  localparam int EIOCP_MAX_STEPS = (EIOCP_MAX_DELAY_MS * 1000) / EIOCP_STEP_US;
  localparam int EIOCP_SEL_BIT = 7;
  localparam logic [3:0] EIOCP_DIR_RST = 4'h0;
  localparam logic [3:0] EIOCP_OUT_RST = 4'h0;
  typedef enum logic [2:0] {
    EIOCP_GET_DIR, EIOCP_GET_DATA, EIOCP_GET_DELAY, EIOCP_SETTLE,
    EIOCP_SAMPLE, EIOCP_ADC_WAIT, EIOCP_SEND_HI, EIOCP_SEND_LO
  } eiocp_state_t;
endpackage

/* File: design/eiocp_step_timer.sv */
`timescale 1ns/1ps
module eiocp_step_timer
  import eiocp_pkg::*;
#(
  parameter int STEP_CYCLES = EIOCP_STEP_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_start,
  input wire logic [7:0] i_steps,
  output logic o_done
);
  logic [31:0] cyc;
  logic [7:0] steps;
  logic run;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc <= 32'h0;
      steps <= 8'h0;
      run <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cyc <= 32'h0;
        steps <= i_steps;
        run <= (i_steps != 8'h0);
        o_done <= (i_steps == 8'h0);
      end else if (run) begin
        if (cyc == 32'(STEP_CYCLES - 1)) begin
          cyc <= 32'h0;
          steps <= steps - 8'h1;
          if (steps == 8'h1) begin
            run <= 1'b0;
            o_done <= 1'b1;
          end
        end else begin
          cyc <= cyc + 32'h1;
        end
      end
    end
  end
endmodule

/* File: design/eiocp_port.sv */
`timescale 1ns/1ps
module eiocp_port
  import eiocp_pkg::*;
#(
  parameter int STEP_CYCLES = EIOCP_STEP_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // command bytes from host
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_data,
  output logic o_cmd_ready,
  // result bytes to host
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  input wire logic i_rsp_ready,
  // digital lines
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  // converter
  output logic o_adc_start,
  input wire logic i_adc_done,
  input wire logic [11:0] i_adc_code,
  // status
  output logic o_busy
);
  eiocp_state_t state;
  logic [3:0] io_s1, io_s2;
  logic adc_sel;
  logic [7:0] steps;
  logic [15:0] result;
  logic tmr_start, tmr_done;

  eiocp_step_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(tmr_start),
    .i_steps(steps),
    .o_done(tmr_done)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      io_s1 <= i_io;
      io_s2 <= io_s1;
    end
  end

  wire cmd_take = i_cmd_valid && o_cmd_ready;
  wire rsp_take = o_rsp_valid && i_rsp_ready;

  // phase decodes shared by several registers
  wire dir_take = cmd_take && (state == EIOCP_GET_DIR);
  wire data_take = cmd_take && (state == EIOCP_GET_DATA);
  wire delay_take = cmd_take && (state == EIOCP_GET_DELAY);
  wire last_take = rsp_take && (state == EIOCP_SEND_LO);

  // upper byte when hi is set, else lower byte
  function automatic logic [7:0] pick_byte(input logic [15:0] val, input logic hi);
    pick_byte = hi ? val[15:8] : val[7:0];
  endfunction

  // settling steps beyond the 25 ms ceiling are cut back
  function automatic logic [7:0] clamp_steps(input logic [7:0] raw);
    clamp_steps = (raw > 8'(EIOCP_MAX_STEPS)) ? 8'(EIOCP_MAX_STEPS) : raw;
  endfunction

  // phase sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= EIOCP_GET_DIR;
    end else begin
      unique case (state)
        EIOCP_GET_DIR: if (cmd_take) begin
          state <= EIOCP_GET_DATA;
        end
        EIOCP_GET_DATA: if (cmd_take) begin
          state <= EIOCP_GET_DELAY;
        end
        EIOCP_GET_DELAY: if (cmd_take) begin
          state <= EIOCP_SETTLE;
        end
        EIOCP_SETTLE: if (tmr_done) begin
          state <= EIOCP_SAMPLE;
        end
        EIOCP_SAMPLE: begin
          if (adc_sel) begin
            state <= EIOCP_ADC_WAIT;
          end else begin
            state <= EIOCP_SEND_HI;
          end
        end
        EIOCP_ADC_WAIT: if (i_adc_done) begin
          state <= EIOCP_SEND_HI;
        end
        EIOCP_SEND_HI: if (rsp_take) begin
          state <= EIOCP_SEND_LO;
        end
        EIOCP_SEND_LO: if (rsp_take) begin
          state <= EIOCP_GET_DIR;
        end
      endcase
    end
  end

  // line direction and drive levels, held until the next direction or data byte rewrites them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_io_oe <= EIOCP_DIR_RST;
      o_io <= EIOCP_OUT_RST;
    end else begin
      if (dir_take) begin
        o_io_oe <= i_cmd_data[3:0];
      end
      if (data_take) begin
        o_io <= i_cmd_data[3:0];
      end
    end
  end

  // readback choice from the data byte msb
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      adc_sel <= 1'b0;
    end else if (data_take) begin
      adc_sel <= i_cmd_data[EIOCP_SEL_BIT];
    end
  end

  // settling step count for the timer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      steps <= 8'h0;
    end else if (delay_take) begin
      steps <= clamp_steps(i_cmd_data);
    end
  end

  // timer starts the edge after the delay byte, once steps is loaded
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr_start <= 1'b0;
    end else begin
      tmr_start <= delay_take;
    end
  end

  // intake closes from the delay byte until the last result byte leaves
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_ready <= 1'b1;
    end else if (delay_take) begin
      o_cmd_ready <= 1'b0;
    end else if (last_take) begin
      o_cmd_ready <= 1'b1;
    end
  end

  // busy from the first command byte to the last result byte
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
    end else if (dir_take) begin
      o_busy <= 1'b1;
    end else if (last_take) begin
      o_busy <= 1'b0;
    end
  end

  // one-cycle start pulse, only after settling
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_adc_start <= 1'b0;
    end else begin
      o_adc_start <= (state == EIOCP_SAMPLE) && adc_sel;
    end
  end

  // result word, digital levels in the low nibble
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result <= 16'h0;
    end else if ((state == EIOCP_SAMPLE) && !adc_sel) begin
      result <= {12'h000, io_s2};
    end else if ((state == EIOCP_ADC_WAIT) && i_adc_done) begin
      result <= {4'h0, i_adc_code};
    end
  end

  // result valid rises in the upper-byte phase, falls with the last byte
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
    end else if (state == EIOCP_SEND_HI) begin
      o_rsp_valid <= 1'b1;
    end else if (last_take) begin
      o_rsp_valid <= 1'b0;
    end
  end

  // upper byte first, each byte held until the host takes it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_data <= 8'h0;
    end else if ((state == EIOCP_SEND_HI) && !o_rsp_valid) begin
      o_rsp_data <= pick_byte(result, 1'b1);
    end else if ((state == EIOCP_SEND_HI) && rsp_take) begin
      o_rsp_data <= pick_byte(result, 1'b0);
    end
  end
endmodule

/* File: test/eiocp_port_assertions.sv */
`timescale 1ns/1ps
module eiocp_port_chk (
  input wire logic i_clk, i_rst_n, i_cmd_valid, o_cmd_ready, i_rsp_ready,
  input wire logic o_rsp_valid, o_adc_start, i_adc_done, o_busy,
  input wire logic [7:0] i_cmd_data, o_rsp_data,
  input wire logic [3:0] o_io_oe,
  input wire logic [11:0] i_adc_code
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire first = i_cmd_valid && o_cmd_ready && !o_busy;
  hold_rsp_a: assert property (
    o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_data)) else $error("rsp");
  no_cmd_a: assert property (o_rsp_valid |-> !o_cmd_ready) else $error("cmd");
  conv_a: assert property (
    o_adc_start |=> !o_adc_start && !o_rsp_valid) else $error("start");
  hi_zero_a: assert property (
    $rose(o_rsp_valid) |-> o_rsp_data[7:4] == 4'h0) else $error("hi");
  adc_hi_a: assert property (i_adc_done |-> ##[1:3]
    (o_rsp_valid && o_rsp_data == {4'h0, i_adc_code[11:8]})) else $error("adc");
  dir_set_a: assert property (
    first |=> o_io_oe == $past(i_cmd_data[3:0])) else $error("dir");
  busy_set_a: assert property (first |=> o_busy) else $error("busy");
  settle_a: assert property (
    $fell(o_cmd_ready) |-> !o_rsp_valid [*3]) else $error("settle");
  dir_hold_a: assert property (!o_cmd_ready |-> $stable(o_io_oe)) else $error("oe");
endmodule
bind eiocp_port eiocp_port_chk u_chk(.*);

/* File: test/eiocp_adc_model.sv */
`timescale 1ns/1ps
module eiocp_adc_model #(parameter logic [11:0] CODE = 12'hFFF) (
  input wire logic i_clk,
  input wire logic i_start,
  output logic o_done = 1'b0,
  output logic [11:0] o_code
);
  assign o_code = CODE;
  always @(posedge i_clk) o_done <= i_start;
endmodule

/* File: test/tb_eiocp_port.sv */
`timescale 1ns/1ps
module tb_eiocp_port;
  logic i_clk = 0, i_rst_n = 0, i_cmd_valid = 0, i_rsp_ready = 0;
  logic o_cmd_ready, o_rsp_valid, o_adc_start, i_adc_done, o_busy;
  logic [7:0] i_cmd_data = 8'h00, o_rsp_data;
  logic [3:0] ext = 4'h9, i_io, o_io, o_io_oe;
  logic [11:0] i_adc_code;
  int mismatches = 0, checked = 0, w;
  localparam int STEP = 4;
  always #2 i_clk = ~i_clk;
  // pins: driven lines show the drive level, others the outside level
  assign i_io = (o_io & o_io_oe) | (ext & ~o_io_oe);
  eiocp_port #(.STEP_CYCLES(STEP)) uut(.*);
  eiocp_adc_model adc(.i_clk, .i_start(o_adc_start), .o_done(i_adc_done), .o_code(i_adc_code));
  task chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task put(input logic [7:0] d);
    @(negedge i_clk);
    i_cmd_valid = 1;
    i_cmd_data = d;
    do @(posedge i_clk); while (!o_cmd_ready);
  endtask
  task run(input logic [7:0] dir, dat, dly, input logic [15:0] e);
    int st;
    st = (dly > eiocp_pkg::EIOCP_MAX_STEPS) ? eiocp_pkg::EIOCP_MAX_STEPS : int'(dly);
    put(dir);
    put(dat);
    put(dly);
    @(negedge i_clk);
    i_cmd_valid = 0;
    chk("oe", o_io_oe, dir[3:0]);
    chk("out", o_io, dat[3:0]);
    for (w = 0; !o_rsp_valid; w++) @(negedge i_clk);
    chk("wait", w > st * STEP, 1);
    chk("span", w <= st * STEP + 8, 1);
    chk("hi", o_rsp_data, e[15:8]);
    i_rsp_ready = 1;
    @(negedge i_clk);
    chk("lo", o_rsp_data, e[7:0]);
    chk("lo_valid", o_rsp_valid, 1);
    @(negedge i_clk);
    chk("rsp_end", o_rsp_valid, 0);
    chk("rdy_back", o_cmd_ready, 1);
    i_rsp_ready = 0;
  endtask
  task t_dig; run(8'h05, 8'h0E, 8'h00, 16'h000C); endtask
  task t_adc; run(8'h0F, 8'h83, 8'h02, 16'h0FFF); endtask
  task t_inp;
    ext = 4'h6;
    run(8'h00, 8'h0F, 8'h01, 16'h0006);
  endtask
  task t_clamp; run(8'h00, 8'h00, 8'hFF, 16'h0006); endtask
  task t_rst;
    put(8'h0F);
    @(negedge i_clk);
    chk("busy", o_busy, 1);
    i_cmd_valid = 0;
    i_rst_n = 0;
    #1;
    chk("rst_oe", o_io_oe, 0);
    chk("rst_busy", o_busy, 0);
    chk("rst_rdy", o_cmd_ready, 1);
    @(negedge i_clk);
    i_rst_n = 1;
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge i_clk);
    i_rst_n = 1;
    t_dig;
    t_adc;
    t_rst;
    t_inp;
    t_clamp;
    conclude;
  end
  initial begin
    #20000;
    mismatches++;
    conclude;
  end
endmodule
